/* File: emwt_pkg.sv */
// shared constants for the external memory wait and timing block
package emwt_pkg;

  // register byte offsets on the APB
  localparam logic [7:0]  EMWT_OFS_ROM0    = 8'h00;
  localparam logic [7:0]  EMWT_OFS_ROM4    = 8'h04;
  localparam logic [7:0]  EMWT_OFS_SD2     = 8'h08;
  localparam logic [7:0]  EMWT_OFS_SD3     = 8'h0C;
  localparam logic [7:0]  EMWT_OFS_NORM    = 8'h10;

  // values after reset (all five happen to share one pattern)
  localparam logic [31:0] EMWT_RST_ROM     = 32'h0000_0540;
  localparam logic [31:0] EMWT_RST_SD2     = 32'h0000_0540;
  localparam logic [31:0] EMWT_RST_SD3     = 32'h0000_0540;
  localparam logic [31:0] EMWT_RST_NORM    = 32'h0000_0540;

  // writable bits of each register
  localparam logic [31:0] EMWT_WMASK_ROM   = 32'h0003_1FC3;
  localparam logic [31:0] EMWT_WMASK_SD2   = 32'h0000_0180;
  localparam logic [31:0] EMWT_WMASK_SD3   = 32'h0000_6D98;
  localparam logic [31:0] EMWT_WMASK_NORM  = 32'h0007_1FC3;

  // reserved bits that always read as one
  localparam logic [31:0] EMWT_ONES_SD2    = 32'h0000_0440;
  localparam logic [31:0] EMWT_ONES_SD3    = 32'h0000_0040;

  // field positions (low bit of each field)
  localparam int EMWT_POS_BURST  = 16;  // burst_stall_count, 2 bits
  localparam int EMWT_POS_WRITE  = 16;  // write_stall_count, 3 bits
  localparam int EMWT_POS_SETUP  = 11;  // strobe_setup_delay, 2 bits
  localparam int EMWT_POS_WAIT   = 7;   // access wait code, 4 bits
  localparam int EMWT_POS_MASK   = 6;   // ext_stall_mask
  localparam int EMWT_POS_HOLD   = 0;   // strobe_hold_delay, 2 bits
  localparam int EMWT_POS_CL     = 7;   // column latency, 2 bits
  localparam int EMWT_POS_TRP    = 13;  // precharge_to_activate_gap
  localparam int EMWT_POS_TRCD   = 10;  // activate_to_access_gap
  localparam int EMWT_POS_TRWL   = 3;   // write_to_precharge_gap

  // access areas served by the stall sequencer
  typedef enum logic [1:0] {
    EMWT_AREA_ROM0 = 2'h0,
    EMWT_AREA_ROM4 = 2'h1,
    EMWT_AREA_NORM = 2'h2
  } emwt_area_t;

  // largest legal wait count; prohibited codes clamp to it
  localparam logic [4:0] EMWT_WAIT_MAX = 5'h18;

  // access wait code to wait cycles
  function automatic logic [4:0] emwt_wait_decode(input logic [3:0] code);
    logic [4:0] cycles;
    cycles = EMWT_WAIT_MAX;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: cycles = {1'b0, code};
      4'h7: cycles = 5'h08;
      4'h8: cycles = 5'h0A;
      4'h9: cycles = 5'h0C;
      4'hA: cycles = 5'h0E;
      4'hB: cycles = 5'h12;
      default: cycles = EMWT_WAIT_MAX;
    endcase
    return cycles;
  endfunction

endpackage

/* File: emwt_stall_seq.sv */
`timescale 1ns/10ps
`default_nettype none
// counts programmed wait cycles, then stretches while the external wait is honoured
module emwt_stall_seq
  import emwt_pkg::*;
#(
  parameter int CW = 5              // width of the wait count
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // request
  input  wire logic          start,
  input  wire logic [CW-1:0] count,
  input  wire logic          mask,
  input  wire logic          ext_wait,
  // status
  output logic               busy,
  output logic               done
);

  // one-hot sequencer states
  typedef enum logic [2:0] {
    EMWT_SQ_IDLE   = 3'b001,
    EMWT_SQ_COUNT  = 3'b010,
    EMWT_SQ_EXTEND = 3'b100
  } emwt_sq_t;

  emwt_sq_t        state,  next_state;   // sequencer state
  logic [CW-1:0]   cnt,    next_cnt;     // remaining wait cycles
  logic            msk,    next_msk;     // mask latched per access
  logic            next_busy;
  logic            next_done;

  // next state; the mask is frozen at start so a rewrite mid access is harmless
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_msk   = msk;
    next_done  = 1'b0;
    case (state)
      EMWT_SQ_IDLE: begin
        if (start) begin
          next_state = EMWT_SQ_COUNT;
          next_cnt   = count;
          next_msk   = mask;
        end
      end
      EMWT_SQ_COUNT: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        // R4: mask gates ext wait
        end else if (!msk && ext_wait) begin
          next_state = EMWT_SQ_EXTEND;
        end else begin
          next_state = EMWT_SQ_IDLE;
          next_done  = 1'b1;
        end
      end
      EMWT_SQ_EXTEND: begin
        // R17: stretch until released
        if (!ext_wait) begin
          next_state = EMWT_SQ_IDLE;
          next_done  = 1'b1;
        end
      end
      default: next_state = EMWT_SQ_IDLE;
    endcase
    next_busy = (next_state != EMWT_SQ_IDLE);
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EMWT_SQ_IDLE;
      cnt   <= '0;
      msk   <= 1'b1;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      msk   <= next_msk;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

endmodule // emwt_stall_seq
`default_nettype wire

/* File: emwt_gap_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// least spacing between two sdram commands; allowed rises gap+1 cycles after trigger
module emwt_gap_timer
  import emwt_pkg::*;
#(
  parameter int GW = 2              // width of the gap code
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // trigger and spacing
  input  wire logic          trigger,
  input  wire logic [GW-1:0] gap,
  // result
  output logic               allowed
);

  logic [GW-1:0] cnt, next_cnt;      // cycles still to wait
  logic          next_allowed;

  // reload on trigger, else count down to zero
  always_comb begin
    next_cnt = cnt;
    if (trigger) begin
      next_cnt = gap;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
    next_allowed = (next_cnt == '0);
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= '0;
      allowed <= 1'b1;
    end else begin
      cnt     <= next_cnt;
      allowed <= next_allowed;
    end
  end

endmodule // emwt_gap_timer
`default_nettype wire

/* File: emwt_timing_cfg.sv */
// Notes on behaviour
// R1: wait code table 0..24, three codes prohibited
// R2: nonzero write count overrides access wait
// R3: write code zero reuses access wait
// R4: stall mask zero honours external wait
// R5: strobe setup delay half-cycle steps after select
// R6: strobe hold delay half-cycle steps after strobe
// R7: burst beats after first get burst count
// R8: burst first beat and writes use access code
// R9: area two column latency one to four
// R10: area three column latency one to four
// R11: software mirrors latency into mode settings
// R12: precharge to activate least spacing
// R13: activate to access least spacing
// R14: store to precharge spacing
// R15: area three gaps govern both sdram areas
// R16: fixed reserved ones read one
// R17: honoured external wait extends the access
// R18: software avoids prohibited wait codes
`timescale 1ns/10ps
`default_nettype none
module emwt_timing_cfg
  import emwt_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // access request from the bus engine
  input  wire logic        acc_start,
  input  wire logic [1:0]  acc_area,
  input  wire logic        acc_write,
  input  wire logic        acc_burst_next,
  input  wire logic        ext_wait,
  // access timing results
  output logic             acc_busy,
  output logic             acc_done,
  output logic [1:0]       acc_setup_delay,
  output logic [1:0]       acc_hold_delay,
  output logic [4:0]       acc_wait_cycles,
  // sdram command events
  input  wire logic        sd_precharge,
  input  wire logic        sd_activate,
  input  wire logic        sd_store,
  // sdram spacing and latency results
  output logic             sd_activate_ok,
  output logic             sd_access_ok,
  output logic             sd_precharge_ok,
  output logic [2:0]       sd_area2_latency,
  output logic [2:0]       sd_area3_latency
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [31:0] burst_rom_area0_timing, next_burst_rom_area0_timing;
  logic [31:0] burst_rom_area4_timing, next_burst_rom_area4_timing;
  logic [31:0] sdram_area2_latency,    next_sdram_area2_latency;
  logic [31:0] sdram_area3_timing,     next_sdram_area3_timing;
  logic [31:0] normal_area_timing,     next_normal_area_timing;

  // apb answer state
  logic        next_pready;             // answer flag for access phase
  logic [31:0] next_prdata;             // read data captured with answer
  logic        next_pslverr;            // unmapped address flag
  logic        apb_access;              // access phase, not yet answered
  logic        apb_commit;              // edge where master samples pready
  logic        hit_rom0;
  logic        hit_rom4;
  logic        hit_sd2;
  logic        hit_sd3;
  logic        hit_norm;
  logic        hit_any;

  // address decode; anything outside the five words is refused
  always_comb begin
    hit_rom0 = 1'b0;
    hit_rom4 = 1'b0;
    hit_sd2  = 1'b0;
    hit_sd3  = 1'b0;
    hit_norm = 1'b0;
    if (paddr == EMWT_OFS_ROM0) begin
      hit_rom0 = 1'b1;
    end else if (paddr == EMWT_OFS_ROM4) begin
      hit_rom4 = 1'b1;
    end else if (paddr == EMWT_OFS_SD2) begin
      hit_sd2 = 1'b1;
    end else if (paddr == EMWT_OFS_SD3) begin
      hit_sd3 = 1'b1;
    end else if (paddr == EMWT_OFS_NORM) begin
      hit_norm = 1'b1;
    end
    hit_any = hit_rom0 | hit_rom4 | hit_sd2 | hit_sd3 | hit_norm;
  end

  // apb handshake: answer one cycle into the access phase, so every
  // transfer costs setup + two access cycles; keeps prdata a clean flop
  always_comb begin
    apb_access   = psel && penable && !pready;
    apb_commit   = psel && penable && pready;
    next_pready  = apb_access;
    next_pslverr = apb_access && !hit_any;
    next_prdata  = prdata;
    if (apb_access) begin
      next_prdata = 32'h0000_0000;
      // R16: fixed ones show on read
      if (hit_rom0) begin
        next_prdata = burst_rom_area0_timing;
      end else if (hit_rom4) begin
        next_prdata = burst_rom_area4_timing;
      end else if (hit_sd2) begin
        next_prdata = sdram_area2_latency | EMWT_ONES_SD2;
      end else if (hit_sd3) begin
        next_prdata = sdram_area3_timing | EMWT_ONES_SD3;
      end else if (hit_norm) begin
        next_prdata = normal_area_timing;
      end
    end
  end

  // register writes take effect at the committing edge only;
  // reserved bits are forced, so a careless write cannot disturb them
  always_comb begin
    next_burst_rom_area0_timing = burst_rom_area0_timing;
    next_burst_rom_area4_timing = burst_rom_area4_timing;
    next_sdram_area2_latency    = sdram_area2_latency;
    next_sdram_area3_timing     = sdram_area3_timing;
    next_normal_area_timing     = normal_area_timing;
    if (apb_commit && pwrite && !pslverr) begin
      if (hit_rom0) begin
        next_burst_rom_area0_timing = pwdata & EMWT_WMASK_ROM;
      end else if (hit_rom4) begin
        next_burst_rom_area4_timing = pwdata & EMWT_WMASK_ROM;
      end else if (hit_sd2) begin
        // R16: reserved ones kept
        next_sdram_area2_latency = (pwdata & EMWT_WMASK_SD2) | EMWT_ONES_SD2;
      end else if (hit_sd3) begin
        next_sdram_area3_timing = (pwdata & EMWT_WMASK_SD3) | EMWT_ONES_SD3;
      end else if (hit_norm) begin
        next_normal_area_timing = pwdata & EMWT_WMASK_NORM;
      end
    end
  end

  // register file and apb answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_rom_area0_timing <= EMWT_RST_ROM;
      burst_rom_area4_timing <= EMWT_RST_ROM;
      sdram_area2_latency    <= EMWT_RST_SD2;
      sdram_area3_timing     <= EMWT_RST_SD3;
      normal_area_timing     <= EMWT_RST_NORM;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      prdata                 <= 32'h0000_0000;
    end else begin
      burst_rom_area0_timing <= next_burst_rom_area0_timing;
      burst_rom_area4_timing <= next_burst_rom_area4_timing;
      sdram_area2_latency    <= next_sdram_area2_latency;
      sdram_area3_timing     <= next_sdram_area3_timing;
      normal_area_timing     <= next_normal_area_timing;
      pready                 <= next_pready;
      pslverr                <= next_pslverr;
      prdata                 <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // access wait selection
  // ---------------------------------------------------------------
  logic [31:0] sel_reg;                 // register of the addressed area
  logic [2:0]  write_stall_count;       // write code, normal area only
  logic [1:0]  burst_stall_count;       // later beat count, rom areas
  logic [3:0]  wait_code;               // general access wait code
  logic        ext_stall_mask;          // external wait mask of the area
  logic [1:0]  strobe_setup_delay;
  logic [1:0]  strobe_hold_delay;
  logic [4:0]  sel_wait;                // chosen wait cycles
  logic [4:0]  next_acc_wait_cycles;
  logic [1:0]  next_acc_setup_delay;
  logic [1:0]  next_acc_hold_delay;
  logic        seq_start;               // start accepted by the sequencer

  // pick the area register; reserved area code falls back to normal space
  always_comb begin
    if (acc_area == EMWT_AREA_ROM0) begin
      sel_reg = burst_rom_area0_timing;
    end else if (acc_area == EMWT_AREA_ROM4) begin
      sel_reg = burst_rom_area4_timing;
    end else begin
      sel_reg = normal_area_timing;
    end
    write_stall_count  = normal_area_timing[EMWT_POS_WRITE +: 3];
    burst_stall_count  = sel_reg[EMWT_POS_BURST +: 2];
    wait_code          = sel_reg[EMWT_POS_WAIT +: 4];
    ext_stall_mask     = sel_reg[EMWT_POS_MASK];
    strobe_setup_delay = sel_reg[EMWT_POS_SETUP +: 2];
    strobe_hold_delay  = sel_reg[EMWT_POS_HOLD +: 2];
  end

  // wait count for this beat; prohibited codes clamp to the largest count
  always_comb begin
    // R1: table decode
    // R18: prohibited codes clamp
    sel_wait = emwt_wait_decode(wait_code);
    if ((acc_area == EMWT_AREA_ROM0) || (acc_area == EMWT_AREA_ROM4)) begin
      // R7: later burst read beats
      if (acc_burst_next && !acc_write) begin
        sel_wait = {3'b000, burst_stall_count};
      end
      // R8: first beat keeps access code
    end else if (acc_write && (write_stall_count != 3'b000)) begin
      // R2: write count overrides
      // R3: code n gives n-1 cycles
      sel_wait = {2'b00, write_stall_count} - 5'h01;
    end
  end

  // latch the timing of each accepted access; held until the next one
  always_comb begin
    seq_start            = acc_start && !acc_busy;
    next_acc_wait_cycles = acc_wait_cycles;
    next_acc_setup_delay = acc_setup_delay;
    next_acc_hold_delay  = acc_hold_delay;
    if (seq_start) begin
      next_acc_wait_cycles = sel_wait;
      // R5: setup code, half cycles
      next_acc_setup_delay = strobe_setup_delay;
      // R6: hold code, half cycles
      next_acc_hold_delay  = strobe_hold_delay;
    end
  end

  // access timing flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_wait_cycles <= 5'h00;
      acc_setup_delay <= 2'h0;
      acc_hold_delay  <= 2'h0;
    end else begin
      acc_wait_cycles <= next_acc_wait_cycles;
      acc_setup_delay <= next_acc_setup_delay;
      acc_hold_delay  <= next_acc_hold_delay;
    end
  end

  // wait counter with external stretch
  emwt_stall_seq #(
    .CW       (5)
  ) u_stall (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (seq_start),
    .count    (sel_wait),
    .mask     (ext_stall_mask),
    .ext_wait (ext_wait),
    .busy     (acc_busy),
    .done     (acc_done)
  );

  // ---------------------------------------------------------------
  // sdram latency and command spacing
  // ---------------------------------------------------------------
  logic [1:0] area2_column_latency;
  logic [1:0] area3_column_latency;
  logic [1:0] precharge_to_activate_gap;
  logic [1:0] activate_to_access_gap;
  logic [1:0] write_to_precharge_gap;
  logic [2:0] next_sd_area2_latency;
  logic [2:0] next_sd_area3_latency;

  // field extraction and latency decode (code + 1 cycles)
  always_comb begin
    area2_column_latency      = sdram_area2_latency[EMWT_POS_CL +: 2];
    area3_column_latency      = sdram_area3_timing[EMWT_POS_CL +: 2];
    // R15: one set for both areas
    precharge_to_activate_gap = sdram_area3_timing[EMWT_POS_TRP +: 2];
    activate_to_access_gap    = sdram_area3_timing[EMWT_POS_TRCD +: 2];
    write_to_precharge_gap    = sdram_area3_timing[EMWT_POS_TRWL +: 2];
    // R9: area two latency
    next_sd_area2_latency     = {1'b0, area2_column_latency} + 3'h1;
    // R10: area three latency
    next_sd_area3_latency     = {1'b0, area3_column_latency} + 3'h1;
  end

  // latency flops; the mode settings in the sdram itself are software's job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_area2_latency <= 3'h3;
      sd_area3_latency <= 3'h3;
    end else begin
      sd_area2_latency <= next_sd_area2_latency;
      sd_area3_latency <= next_sd_area3_latency;
    end
  end

  // R12: precharge to activate
  emwt_gap_timer #(
    .GW      (2)
  ) u_gap_rp (
    .pclk    (pclk),
    .presetn (presetn),
    .trigger (sd_precharge),
    .gap     (precharge_to_activate_gap),
    .allowed (sd_activate_ok)
  );

  // R13: activate to access
  emwt_gap_timer #(
    .GW      (2)
  ) u_gap_rcd (
    .pclk    (pclk),
    .presetn (presetn),
    .trigger (sd_activate),
    .gap     (activate_to_access_gap),
    .allowed (sd_access_ok)
  );

  // R14: store to precharge
  emwt_gap_timer #(
    .GW      (2)
  ) u_gap_rwl (
    .pclk    (pclk),
    .presetn (presetn),
    .trigger (sd_store),
    .gap     (write_to_precharge_gap),
    .allowed (sd_precharge_ok)
  );

endmodule // emwt_timing_cfg
`default_nettype wire

/* File: emwt_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far-side memory: holds its wait pin for a set number of cycles per access
module emwt_mem_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // select seen by the memory and the stall it will hold
  input  wire logic       acc_start,
  input  wire logic [4:0] stall_len,
  // wait pin back to the controller
  output logic            ext_wait
);
  logic [4:0] left;       // stall cycles still to hold
  logic [4:0] next_left;  // next stall count
  // re-arm on each select; count down while stalling
  always_comb begin
    next_left = left;
    if (acc_start) begin
      next_left = stall_len;
    end else if (left != 5'h00) begin
      next_left = left - 5'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 5'h00;
    end else begin
      left <= next_left;
    end
  end
  // pin idles low once the stall runs out, so no stale level lingers
  assign ext_wait = (left != 5'h00);
endmodule  // emwt_mem_model
`default_nettype wire

/* File: emwt_timing_cfg_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// watches handshake, wait and spacing outputs of the timing block
module emwt_timing_cfg_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb side
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // access side
  input wire logic       acc_start,
  input wire logic       acc_busy,
  input wire logic       acc_done,
  input wire logic [4:0] acc_wait_cycles,
  // sdram side
  input wire logic       sd_precharge,
  input wire logic       sd_activate,
  input wire logic       sd_store,
  input wire logic       sd_activate_ok,
  input wire logic       sd_access_ok,
  input wire logic       sd_precharge_ok,
  input wire logic [2:0] sd_area2_latency
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  busy_start_a: assert property (acc_start && !acc_busy |=> acc_busy)
    else $error("accepted beat not busy");
  done_end_a: assert property (acc_done |-> !acc_busy && $past(acc_busy))
    else $error("done not ending a busy beat");
  done_pulse_a: assert property (acc_done |=> !acc_done)
    else $error("done longer than one cycle");
  wait_max_a: assert property (acc_wait_cycles <= 5'h18)
    else $error("wait count above largest legal");
  act_fall_a: assert property ($fell(sd_access_ok) |-> $past(sd_activate))
    else $error("access gap fell without activate");
  act_bound_a: assert property (!sd_activate [*4] |-> sd_access_ok)
    else $error("access gap too long");
  pre_bound_a: assert property (!sd_precharge [*4] |-> sd_activate_ok)
    else $error("activate gap too long");
  store_bound_a: assert property (!sd_store [*4] |-> sd_precharge_ok)
    else $error("precharge gap too long");
  lat_range_a: assert property (sd_area2_latency != 3'h0 && sd_area2_latency <= 3'h4)
    else $error("area two latency out of range");
  cover property (acc_done);
  cover property ($fell(sd_access_ok));
  cover property (pslverr);
endmodule  // emwt_timing_cfg_chk
bind emwt_timing_cfg emwt_timing_cfg_chk emwt_timing_cfg_chk_i (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .acc_start, .acc_busy, .acc_done,
  .acc_wait_cycles, .sd_precharge, .sd_activate, .sd_store, .sd_activate_ok,
  .sd_access_ok, .sd_precharge_ok, .sd_area2_latency);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import emwt_pkg::*;
;
  // one register row: address, write value, expected read, expected error
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} emwt_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        acc_start, acc_write, acc_burst_next, ext_wait, acc_busy, acc_done, e;
  logic [1:0]  acc_area, acc_setup_delay, acc_hold_delay;
  logic [4:0]  acc_wait_cycles, stall_len;
  logic [2:0]  cmd, oks, sd_area2_latency, sd_area3_latency;
  logic        sd_activate_ok, sd_access_ok, sd_precharge_ok;
  int          errors, cmp_count, n;
  // decoded wait per code; prohibited codes taken as the largest count
  logic [4:0]  wt [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
                           5'h0A, 5'h0C, 5'h0E, 5'h12, 5'h18, 5'h18, 5'h18, 5'h18};
  emwt_row_t   rows [7] = '{
    '{8'h00, 32'hFFFF_FFFF, 32'h0003_1FC3, 1'b0},
    '{8'h04, 32'h0002_0881, 32'h0002_0881, 1'b0},
    '{8'h08, 32'h0000_0180, 32'h0000_05C0, 1'b0},
    '{8'h08, 32'h0000_04C0, 32'h0000_04C0, 1'b0},
    '{8'h0C, 32'h0000_6D98, 32'h0000_6DD8, 1'b0},
    '{8'h10, 32'h0007_1FC3, 32'h0007_1FC3, 1'b0},
    '{8'h14, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  assign oks = {sd_precharge_ok, sd_access_ok, sd_activate_ok};
  // design and far-side memory
  emwt_timing_cfg emwt_timing_cfg_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .acc_start, .acc_area, .acc_write, .acc_burst_next, .ext_wait, .acc_busy, .acc_done,
    .acc_setup_delay, .acc_hold_delay, .acc_wait_cycles, .sd_precharge(cmd[0]),
    .sd_activate(cmd[1]), .sd_store(cmd[2]), .sd_activate_ok, .sd_access_ok,
    .sd_precharge_ok, .sd_area2_latency, .sd_area3_latency);
  emwt_mem_model emwt_mem_model_i (.pclk, .presetn, .acc_start, .stall_len, .ext_wait);
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) errors++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, q);
    chk("pslverr", 32'(xe), 32'(e));
  endtask
  // one access beat; n counts cycles from the start to the done cycle
  task automatic run(input logic [1:0] ar, input logic w, nx, input logic [4:0] xw);
    @(posedge pclk);
    acc_start <= 1'b1;
    acc_area <= ar;
    acc_write <= w;
    acc_burst_next <= nx;
    @(posedge pclk);
    acc_start <= 1'b0;
    n = 1;
    #1;
    while (acc_done !== 1'b1 && n < 60) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("wait", 32'(xw), 32'(acc_wait_cycles));
  endtask
  // one sdram command; n counts cycles until its spacing flag is back
  task automatic gap(input int k, input int x);
    @(posedge pclk);
    cmd[k] <= 1'b1;
    @(posedge pclk);
    cmd <= 3'h0;
    n = 1;
    #1;
    while (oks[k] !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("gap", 32'(x), 32'(n));
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {acc_start, acc_area, acc_write, acc_burst_next, stall_len, cmd} = '0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("lat2", 32'h3, 32'(sd_area2_latency));
    chk("lat3", 32'h3, 32'(sd_area3_latency));
    chk("oks", 32'h7, 32'(oks));
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0000_0540, 1'b0);
    // register rows: read-only bits, fixed ones, unmapped place
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].q, rows[i].e);
    end
    repeat (2) @(posedge pclk);
    chk("lat2", 32'h2, 32'(sd_area2_latency));
    // every wait code, setup and hold codes cycling with its low two bits
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, EMWT_OFS_ROM0, {19'h0, c[1:0], c[3:0], 5'h10, ~c[1:0]});
      run(2'h0, 1'b0, 1'b0, wt[c]);
      chk("cycles", 32'(wt[c]) + 32'h2, 32'(n));
      chk("setup", 32'(c[1:0]), 32'(acc_setup_delay));
      chk("hold", 32'(c[1:0] ^ 2'h3), 32'(acc_hold_delay));
    end
    // burst beats and writes on burst rom
    apb(1'b1, EMWT_OFS_ROM0, 32'h0003_0040);
    run(2'h0, 1'b0, 1'b1, 5'h03);
    chk("cycles", 32'h5, 32'(n));
    run(2'h0, 1'b1, 1'b1, 5'h00);
    run(2'h0, 1'b0, 1'b0, 5'h00);
    // write count overrides, then falls back to the access code
    apb(1'b1, EMWT_OFS_NORM, 32'h0005_0140);
    run(2'h2, 1'b1, 1'b0, 5'h04);
    run(2'h3, 1'b0, 1'b0, 5'h02);
    run(2'h3, 1'b1, 1'b1, 5'h04);
    apb(1'b1, EMWT_OFS_NORM, 32'h0000_0140);
    run(2'h2, 1'b1, 1'b0, 5'h02);
    // external stall honoured, then masked
    stall_len <= 5'h04;
    apb(1'b1, EMWT_OFS_ROM4, 32'h0000_0000);
    run(2'h1, 1'b0, 1'b0, 5'h00);
    chk("stretched", 32'h1, 32'(n >= 5));
    apb(1'b1, EMWT_OFS_ROM4, 32'h0000_0040);
    run(2'h1, 1'b0, 1'b0, 5'h00);
    chk("masked", 32'h2, 32'(n));
    // sdram spacing from the area three register
    apb(1'b1, EMWT_OFS_SD3, 32'h0000_2050);
    gap(0, 2);
    gap(1, 1);
    gap(2, 3);
    chk("lat3", 32'h1, 32'(sd_area3_latency));
    wrap_up();
  end
endmodule  // tb_top
`default_nettype wire
